// ### design/hub_cfg_bank.v
// Hub configuration bytes 00h-07h with status/command behaviour
`timescale 1ns/1ps
`default_nettype none
`include "hub_cfg_defines.vh"
module hub_cfg_bank (
    // Clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rst_b,
    // Byte access from the serial slave engine
    input  wire       i_wr_done,
    input  wire       i_rd_req,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_ack_done,
    // Board inputs
    input  wire       i_dynamic_power,
    input  wire       i_local_supply_detect,
    // Read answer
    output reg  [7:0] o_rdata,
    output reg        o_rvalid,
    // Serial slave control
    output reg        o_slave_reset,
    output reg        o_slave_power_down,
    output reg        o_attach,
    output reg        o_config_lock,
    // Identity codes
    output reg [15:0] o_vendor_code,
    output reg [15:0] o_product_code,
    output reg [15:0] o_release_code,
    // Decoded options
    output reg        o_self_powered,
    output reg        o_led_indicator_support,
    output reg        o_full_speed_only,
    output reg        o_per_port_translator,
    output reg        o_frame_end_packet_off,
    output reg  [1:0] o_overcurrent_sense_mode,
    output reg        o_oc_sense_present,
    output reg        o_port_switch_mode
);

    // ****************************************
    // Storage
    // ****************************************
    reg [7:0] mem_r [0:`BYTE_COUNT-1];
    reg       soft_rst_r;
    reg       lock_r;
    reg       attach_r;
    reg       pd_pend_r;
    reg       pd_r;
    wire      wr_ok;
    wire [7:0] rd_byte;
    wire [63:0] bytes;
    integer   k;

    function [7:0] status_byte;
        input s;
        input l;
        input a;
        begin
            status_byte = `RESET_BYTE; // RULE18 RULE1
            status_byte[`BIT_SOFT_RESET]  = s;
            status_byte[`BIT_CONFIG_LOCK] = l;
            status_byte[`BIT_ATTACH]      = a;
        end
    endfunction

    assign bytes = {mem_r[7], mem_r[6], mem_r[5], mem_r[4], mem_r[3],
                    mem_r[2], mem_r[1],
                    status_byte(soft_rst_r, lock_r, attach_r)};

    hub_cfg_write_gate hub_cfg_write_gate_inst (
        .i_wr_done (i_wr_done && !pd_r),
        .i_addr    (i_addr),
        .i_lock    (lock_r),
        .o_wr_ok   (wr_ok)
    );

    hub_cfg_read_mux hub_cfg_read_mux_inst (
        .i_bytes (bytes),
        .i_addr  (i_addr),
        .o_data  (rd_byte)
    );

    wire cmd_wr = wr_ok && (i_addr == `ADDR_STATUS_CMD);

    // ****************************************
    // Register update
    // ****************************************
    // Soft reset clears the config bytes but not the write-once bits,
    // which only the pin may clear.
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            for (k = 0; k < `BYTE_COUNT; k = k + 1) begin
                mem_r[k] <= `RESET_BYTE;
            end
            soft_rst_r <= 1'b0;
            lock_r     <= 1'b0;
            attach_r   <= 1'b0;
            pd_pend_r  <= 1'b0;
            pd_r       <= 1'b0;
        end else if (soft_rst_r) begin
            for (k = 1; k < `BYTE_COUNT; k = k + 1) begin
                mem_r[k] <= `RESET_BYTE; // RULE2
            end
            soft_rst_r <= 1'b0; // RULE2
        end else begin
            if (cmd_wr) begin
                soft_rst_r <= i_wdata[`BIT_SOFT_RESET]; // RULE2
                if (i_wdata[`BIT_CONFIG_LOCK]) begin
                    lock_r <= 1'b1; // RULE5
                end
                if (i_wdata[`BIT_ATTACH]) begin
                    attach_r  <= 1'b1; // RULE5 RULE6
                    pd_pend_r <= 1'b1;
                end
            end else if (wr_ok && i_addr < `BYTE_COUNT) begin
                mem_r[i_addr[2:0]] <= i_wdata; // RULE7 RULE16
            end
            if (pd_pend_r && i_ack_done) begin
                pd_r <= 1'b1; // RULE6
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_rdata  <= `RESET_BYTE;
            o_rvalid <= 1'b0;
            o_slave_reset      <= 1'b0;
            o_slave_power_down <= 1'b0;
            o_attach           <= 1'b0;
            o_config_lock      <= 1'b0;
            o_vendor_code  <= 16'h0000;
            o_product_code <= 16'h0000;
            o_release_code <= 16'h0000;
            o_self_powered           <= 1'b0;
            o_led_indicator_support  <= 1'b0;
            o_full_speed_only        <= 1'b0;
            o_per_port_translator    <= 1'b0;
            o_frame_end_packet_off   <= 1'b0;
            o_overcurrent_sense_mode <= 2'h0;
            o_oc_sense_present       <= 1'b1;
            o_port_switch_mode       <= 1'b0;
        end else begin
            // Reads leave the bank untouched
            o_rvalid <= i_rd_req && !pd_r; // RULE16
            if (i_rd_req && !pd_r) begin
                o_rdata <= rd_byte; // RULE18
            end
            o_slave_reset      <= soft_rst_r; // RULE2
            o_slave_power_down <= pd_r; // RULE6
            o_attach           <= attach_r; // RULE6
            o_config_lock      <= lock_r; // RULE3
            o_vendor_code  <= {mem_r[2], mem_r[1]}; // RULE7
            o_product_code <= {mem_r[4], mem_r[3]}; // RULE7
            o_release_code <= {mem_r[6], mem_r[5]}; // RULE7
            // Dynamic mode follows the board pin, not the stored bit
            o_self_powered <= i_dynamic_power ? i_local_supply_detect :
                              mem_r[7][`BIT_POWER_SOURCE]; // RULE8
            o_led_indicator_support <= mem_r[7][`BIT_LED_SUPPORT]; // RULE9
            o_full_speed_only       <= mem_r[7][`BIT_FS_ONLY]; // RULE10
            o_per_port_translator   <= mem_r[7][`BIT_PER_PORT_TT]; // RULE11
            o_frame_end_packet_off  <= mem_r[7][`BIT_FEOP_OFF]; // RULE12
            o_overcurrent_sense_mode <=
                mem_r[7][`BIT_OC_HI:`BIT_OC_LO]; // RULE13
            o_oc_sense_present <= !mem_r[7][`BIT_OC_HI]; // RULE13 RULE14
            o_port_switch_mode <= mem_r[7][`BIT_SWITCH_MODE]; // RULE15
        end
    end

endmodule
`default_nettype wire

// ### design/hub_cfg_read_mux.v
// Read data selection for the configuration bytes
`timescale 1ns/1ps
`default_nettype none
`include "hub_cfg_defines.vh"
module hub_cfg_read_mux (
    // Stored bytes
    input  wire [63:0] i_bytes,
    input  wire [7:0]  i_addr,
    // Read data
    output reg  [7:0]  o_data
);
    always @* begin
        if (i_addr < `BYTE_COUNT) begin
            o_data = i_bytes[i_addr[2:0]*8 +: 8];
        end else begin
            o_data = `RESET_BYTE;
        end
    end
endmodule
`default_nettype wire

// ### design/hub_cfg_write_gate.v
// Write qualification: lock window and completion check
`timescale 1ns/1ps
`default_nettype none
`include "hub_cfg_defines.vh"
module hub_cfg_write_gate (
    // Write request
    input  wire       i_wr_done,
    input  wire [7:0] i_addr,
    input  wire       i_lock,
    // Qualified strobe
    output wire       o_wr_ok
);
    // Window runs past 07h; unbacked addresses are simply not stored
    wire in_window = (i_addr >= `ADDR_LOCK_FIRST) &&
                     (i_addr <= `ADDR_LOCK_LAST);
    assign o_wr_ok = i_wr_done && !(i_lock && in_window); // RULE3 RULE17 RULE16
endmodule
`default_nettype wire

// ### include/hub_cfg_defines.vh
// Register offsets, field positions and reset values of the hub config bank
// Functional notes
// (RULE1) Host never writes ones into status/command bits 7 to 3.
// (RULE2) Writing status/command bit 2 resets serial slave and config bytes.
// (RULE3) Lock bit set protects addresses 01h to 10h against writes.
// (RULE4) Host sets the lock only after loading and checking its data.
// (RULE5) Lock and attach bits are write-once; only the reset pin clears them.
// (RULE6) Attach bit signals upstream attach, then powers down the serial slave.
// (RULE7) Vendor, product, release codes stored low byte then high, 01h-06h.
// (RULE8) Options bit 7 picks bus/self power; dynamic mode uses the detect pin.
// (RULE9) Options bit 6 reports whether port LED indicators exist.
// (RULE10) Options bit 5 set forces full-speed-only attachment.
// (RULE11) Options bit 4 picks one shared or per-port transaction translator.
// (RULE12) Options bit 3 set suppresses EOF1 end-of-packet in full speed.
// (RULE13) Options bits 2:1 pick ganged, per-port or no overcurrent sensing.
// (RULE14) Host uses no-sensing encoding only with bus-powered configurations.
// (RULE15) Options bit 0 picks ganged or per-port power switching.
// (RULE16) Registers change only on a correctly completed write-byte access.
// (RULE17) Locked writes to 01h-10h are silently dropped.
// (RULE18) Reserved status/command bits 7 to 3 read as zero.
`ifndef HUB_CFG_DEFINES_VH
`define HUB_CFG_DEFINES_VH

// ****************************************
// Offsets
// ****************************************
`define ADDR_STATUS_CMD    8'h00
`define ADDR_VENDOR_LOW    8'h01
`define ADDR_VENDOR_HIGH   8'h02
`define ADDR_PRODUCT_LOW   8'h03
`define ADDR_PRODUCT_HIGH  8'h04
`define ADDR_RELEASE_LOW   8'h05
`define ADDR_RELEASE_HIGH  8'h06
`define ADDR_OPTIONS_ONE   8'h07
`define ADDR_LOCK_FIRST    8'h01
`define ADDR_LOCK_LAST     8'h10

// ****************************************
// Fields
// ****************************************
`define BIT_SOFT_RESET     2
`define BIT_CONFIG_LOCK    1
`define BIT_ATTACH         0
`define BIT_POWER_SOURCE   7
`define BIT_LED_SUPPORT    6
`define BIT_FS_ONLY        5
`define BIT_PER_PORT_TT    4
`define BIT_FEOP_OFF       3
`define BIT_OC_HI          2
`define BIT_OC_LO          1
`define BIT_SWITCH_MODE    0
`define RESET_BYTE         8'h00
`define BYTE_COUNT         8

`endif

// ### sim/hub_cfg_bank_chk.sv
// Port-level checks of the hub config bank
`timescale 1ns/1ps
`default_nettype none
module hub_cfg_bank_chk (
    input wire logic        i_sys_clk, i_rst_b, i_wr_done, i_rd_req,
    input wire logic        i_ack_done, i_dynamic_power,
    input wire logic        i_local_supply_detect, o_rvalid, o_slave_reset,
    input wire logic        o_slave_power_down, o_attach, o_config_lock,
    input wire logic        o_oc_sense_present, o_self_powered,
    input wire logic [7:0]  i_addr,
    input wire logic [1:0]  o_overcurrent_sense_mode,
    input wire logic [15:0] o_vendor_code, o_product_code
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    locked_drop_a: assert property (
        o_config_lock && i_wr_done && i_addr == 8'h01 |->
        ##2 o_vendor_code == $past(o_vendor_code, 2)) else $error("lk wr");
    lock_keep_a: assert property (o_config_lock |=> o_config_lock)
        else $error("lock lost");
    attach_keep_a: assert property (o_attach |=> o_attach)
        else $error("attach lost");
    soft_clear_a: assert property (o_slave_reset |=>
        !o_slave_reset ##1 (o_vendor_code == 16'h0 &&
        o_product_code == 16'h0)) else $error("soft reset");
    pd_after_ack_a: assert property (
        o_attach && i_ack_done |-> ##[1:2] o_slave_power_down)
        else $error("no power down");
    pd_cause_a: assert property (o_slave_power_down |-> o_attach)
        else $error("early power down");
    pd_silent_a: assert property (o_slave_power_down |=> !o_rvalid)
        else $error("read after power down");
    supply_pin_a: assert property (i_dynamic_power |=>
        o_self_powered == $past(i_local_supply_detect)) else $error("supply");
    oc_present_a: assert property (
        o_oc_sense_present == !o_overcurrent_sense_mode[1]) else $error("oc");
    rvalid_cause_a: assert property (o_rvalid |-> $past(i_rd_req))
        else $error("stray rvalid");
endmodule
`default_nettype wire

// ### sim/hub_cfg_bank_test.sv
// Self-checking bench of the hub config bank
`timescale 1ns/1ps
`default_nettype none
module hub_cfg_bank_test;
    logic i_sys_clk = 1'b0, i_rst_b = 1'b0;
    logic i_dynamic_power = 1'b0, i_local_supply_detect = 1'b0;
    logic i_wr_done, i_rd_req, i_ack_done, o_rvalid, o_slave_reset;
    logic o_slave_power_down, o_attach, o_config_lock, o_self_powered;
    logic o_led_indicator_support, o_full_speed_only, o_oc_sense_present;
    logic o_per_port_translator, o_frame_end_packet_off, o_port_switch_mode;
    logic [1:0]  o_overcurrent_sense_mode;
    logic [7:0]  i_addr, i_wdata, o_rdata, opts;
    logic [15:0] o_vendor_code, o_product_code, o_release_code;
    int          err_total = 0, checks_done = 0;
    assign opts = {o_self_powered, o_led_indicator_support, o_full_speed_only,
        o_per_port_translator, o_frame_end_packet_off,
        o_overcurrent_sense_mode, o_port_switch_mode};
    hub_cfg_bank hub_cfg_bank_inst (.*);
    hub_cfg_host_model hub_cfg_host_model_inst (.i_clk(i_sys_clk),
        .i_rvalid(o_rvalid), .i_rdata(o_rdata), .o_wr(i_wr_done),
        .o_rd(i_rd_req), .o_ack(i_ack_done), .o_addr(i_addr),
        .o_wdata(i_wdata));
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        hub_cfg_host_model_inst.wr_byte(a, d);
    endtask
    task automatic r(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic       ok;
        hub_cfg_host_model_inst.rd_byte(a, q, ok);
        chk({7'h0, ok, q}, {8'h01, exp});
    endtask
    task automatic t_reset();
        for (int i = 0; i < 9; i++) r(i[7:0], 8'h00);
    endtask
    task automatic t_ids();
        for (int i = 1; i < 7; i++) w(i[7:0], 8'h10 + i[7:0]);
        chk(o_vendor_code, 16'h1211);
        chk({o_product_code ^ o_release_code}, 16'h0206);
        r(8'h04, 8'h14);
    endtask
    task automatic t_opts();
        logic [7:0] v [4] = '{8'h3b, 8'hc0, 8'h45, 8'h16};
        foreach (v[i]) begin
            w(8'h07, v[i]);
            chk(opts, v[i]);
            chk(o_oc_sense_present, {15'h0, !v[i][2]});
            r(8'h07, v[i]);
        end
        {i_dynamic_power, i_local_supply_detect} = 2'b11;
        repeat (2) @(posedge i_sys_clk) #1;
        chk(o_self_powered, 1'b1);
        {i_dynamic_power, i_local_supply_detect} = 2'b00;
    endtask
    task automatic t_soft(input logic [7:0] st);
        w(8'h00, 8'h04);
        chk(o_slave_reset, 1'b1);
        repeat (3) @(posedge i_sys_clk) #1;
        chk(o_vendor_code, 16'h0);
        chk(opts, 8'h00);
        r(8'h00, st);
    endtask
    task automatic t_lock();
        w(8'h01, 8'h5a);
        w(8'h00, 8'h02);
        w(8'h01, 8'ha5);
        w(8'h00, 8'h00);
        chk(o_vendor_code, 16'h005a);
        r(8'h00, 8'h02);
        t_soft(8'h02);
        chk(o_config_lock, 1'b1);
    endtask
    task automatic t_attach();
        logic [7:0] q;
        logic       ok;
        w(8'h00, 8'h01);
        repeat (2) @(posedge i_sys_clk) #1;
        chk({o_attach, o_slave_power_down}, 2'b11);
        hub_cfg_host_model_inst.rd_byte(8'h00, q, ok);
        chk(ok, 1'b0);
        w(8'h07, 8'h80);
        chk(o_self_powered, 1'b0);
        i_rst_b = 1'b0;
        repeat (2) @(posedge i_sys_clk) #1;
        i_rst_b = 1'b1;
        @(posedge i_sys_clk) #1;
        chk({o_attach, o_config_lock, o_slave_power_down}, 3'b0);
    endtask
    task automatic give_verdict();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_sys_clk);
        #1 i_rst_b = 1'b1;
        t_reset();
        t_ids();
        t_opts();
        t_soft(8'h00);
        t_lock();
        t_attach();
        give_verdict();
    end
    // Run needs about 125 cycles; this bound cuts a hang short
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
endmodule
bind hub_cfg_bank hub_cfg_bank_chk hub_cfg_bank_chk_inst (.*);
`default_nettype wire

// ### sim/hub_cfg_host_model.sv
// Host-side byte access driver for the config bank
`timescale 1ns/1ps
`default_nettype none
module hub_cfg_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_rvalid,
    input  wire logic [7:0] i_rdata,
    output var  logic       o_wr,
    output var  logic       o_rd,
    output var  logic       o_ack,
    output var  logic [7:0] o_addr,
    output var  logic [7:0] o_wdata
);
    initial {o_wr, o_rd, o_ack, o_addr, o_wdata} = 19'h0;
    // Released lines go to the inverse so stale values never match
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) #1 {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
        @(posedge i_clk) #1 {o_addr, o_wdata, o_wr, o_ack} = {~a, ~d, 2'b01};
        @(posedge i_clk) #1 o_ack = 1'b0;
    endtask
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] q,
                           output logic ok);
        {ok, q} = 9'h0;
        @(posedge i_clk) #1 {o_addr, o_rd} = {a, 1'b1};
        @(posedge i_clk) #1 {o_addr, o_rd} = {~a, 1'b0};
        repeat (2) begin
            if (!ok && i_rvalid === 1'b1) {ok, q} = {1'b1, i_rdata};
            if (!ok) @(posedge i_clk) #1;
        end
    endtask
endmodule
`default_nettype wire
